// ==== design/sfepd_pkg.sv ====
// Constants, types and encodings for the serial flash erase and power-down sequencer.
// Assumes a single 100 MHz system clock and a SPI host sampled as asynchronous pins.
//
// Behaviour
// (RULE_01) 52H plus three address bytes erases 32KB block
// (RULE_02) D8H plus three address bytes erases 64KB block
// (RULE_03) Host sets write enable before any erase
// (RULE_04) Block erase runs only if frame ends at 32
// (RULE_05) Chip erase 60H/C7H runs only on 8-bit frame
// (RULE_06) Chip select rise starts self-timed erase cycle
// (RULE_07) Busy flag high throughout erase, status stays readable
// (RULE_08) Write enable latch cleared before erase completes
// (RULE_09) Block erase on protected block is suppressed
// (RULE_10) Chip erase only with BP2..0 equal complement
// (RULE_11) B9H on 8-bit frame enters sleep after delay
// (RULE_12) Sleep ignores everything except the ABH release
// (RULE_13) Sleep command rejected while a cycle runs
// (RULE_14) Deselected and idle means standby, not sleep
// (RULE_15) Always start in standby after power-up
// (RULE_16) ABH release blocks commands for wake delay
// (RULE_17) ABH ID read: three dummies, ID repeats MSB-first
// (RULE_18) ID read release uses second wake delay
// (RULE_19) Release or ID read ignored while busy
// (RULE_20) Bits MSB first on rising edges; opcode first
// (RULE_21) Cycle times and delays are clock-count parameters
package sfepd_pkg;

  // Opcodes
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OPC_FULL_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OPC_CHIP_ERASE_A     = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B     = 8'hC7;
  localparam logic [7:0] OPC_DEEP_SLEEP       = 8'hB9;
  localparam logic [7:0] OPC_WAKE_AND_ID      = 8'hAB;
  localparam logic [7:0] OPC_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS      = 8'h05;

  // Frame lengths in serial clock rising edges
  localparam logic [5:0] OPC_FRAME_BITS  = 6'h08;
  localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
  localparam logic [5:0] BIT_CNT_MAX     = 6'h3F;

  // Array geometry: 64 blocks of 64KB, block index in address bits 21:16
  localparam int          BLK_IDX_LSB = 16;
  localparam logic [6:0]  NUM_BLOCKS  = 7'h40;

  // Reset values
  localparam logic        WEL_RESET   = 1'b0;
  localparam logic [2:0]  OUT_IDX_TOP = 3'h7;

  // Default timings in device clock cycles
  localparam int unsigned HALF_BLOCK_ERASE_TIME  = 20000;
  localparam int unsigned FULL_BLOCK_ERASE_TIME  = 30000;
  localparam int unsigned WHOLE_ARRAY_ERASE_TIME = 60000;
  localparam int unsigned SLEEP_ENTRY_DELAY      = 300;
  localparam int unsigned WAKE_DELAY             = 300;
  localparam int unsigned WAKE_ID_DELAY          = 200;

  // Device ID returned by the ID read; value is arbitrary
  localparam logic [7:0]  DEVICE_ID_DEFAULT = 8'h5A;

  // Protection configuration
  typedef struct packed {
    logic protect_complement;
    logic protect_bit_4;
    logic protect_bit_3;
    logic protect_bit_2;
    logic protect_bit_1;
    logic protect_bit_0;
  } sfepd_prot_t;

  typedef enum logic [1:0] {
    ER_NONE = 2'h0,
    ER_HALF = 2'h1,
    ER_FULL = 2'h2,
    ER_CHIP = 2'h3
  } sfepd_erase_t;

  // Erase request handed to the array engine
  typedef struct packed {
    sfepd_erase_t kind;
    logic [23:0]  addr;
  } sfepd_erase_req_t;

  // Gray along standby -> erase / entry -> sleep -> wake
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_ERASE   = 3'b001,
    ST_ENTRY   = 3'b100,
    ST_SLEEP   = 3'b101,
    ST_WAKE    = 3'b111
  } sfepd_state_t;

endpackage : sfepd_pkg

// ==== design/sfepd_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no multi-bit coherence.
module sfepd_sync
  import sfepd_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      meta_q   <= reset_val_in;
      sync_out <= reset_val_in;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sfepd_sync

// ==== design/sfepd_timer.sv ====
// Down counter for self-timed cycles and mode delays.
// Assumes load and value come from the same clock domain.
module sfepd_timer
  import sfepd_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);

  logic [W-1:0] cnt_q;

  // Counter; a fresh load restarts it
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else if (load_in) begin
      cnt_q <= count_in;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  // One-cycle pulse as the count runs out
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= !load_in && (cnt_q == W'(1));
    end
  end

endmodule : sfepd_timer

// ==== design/sfepd_top.sv ====
// Command sequencer for block/chip erase, deep sleep and wake/ID read.
// Assumes SPI pins are asynchronous and sampled by clock_in at 100 MHz;
// the serial clock must stay well below a quarter of that rate.
module sfepd_top
  import sfepd_pkg::*;
#(
  parameter int unsigned HALF_BLOCK_CYC = HALF_BLOCK_ERASE_TIME, // RULE_21
  parameter int unsigned FULL_BLOCK_CYC = FULL_BLOCK_ERASE_TIME,
  parameter int unsigned WHOLE_CHIP_CYC = WHOLE_ARRAY_ERASE_TIME,
  parameter int unsigned SLEEP_CYC      = SLEEP_ENTRY_DELAY,
  parameter int unsigned WAKE_CYC       = WAKE_DELAY,
  parameter int unsigned WAKE_ID_CYC    = WAKE_ID_DELAY,
  parameter logic [7:0]  DEVICE_ID      = DEVICE_ID_DEFAULT
) (
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  input  wire logic             cs_n_in,
  input  wire logic             sclk_in,
  input  wire logic             si_in,
  input  wire sfepd_prot_t      prot_in,
  output logic                  so_out,
  output logic                  so_oe_n_out,
  output logic                  busy_flag_out,
  output logic                  write_enable_latch_out,
  output logic                  deep_sleep_out,
  output logic                  standby_out,
  output logic                  erase_start_out,
  output sfepd_erase_req_t      erase_req_out
);

  localparam int TW = 32;

  // Refuse timings the counter cannot serve
  if (HALF_BLOCK_CYC < 2 || FULL_BLOCK_CYC < 2 || WHOLE_CHIP_CYC < 2 ||
      SLEEP_CYC < 2 || WAKE_CYC < 2 || WAKE_ID_CYC < 2) begin : g_bad_timing
    $error("sfepd_top: every timing must be at least 2 cycles");
  end

  logic [2:0]    pins_s;
  logic          cs_n_s;
  logic          sclk_s;
  logic          si_s;
  logic          sclk_d_q;
  logic          cs_n_d_q;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          cs_rise;
  logic [5:0]    bit_cnt_q;
  logic [31:0]   shift_q;
  logic [7:0]    opc_q;
  logic [2:0]    out_idx_q;
  logic          wel_q;
  sfepd_state_t  state_q;
  sfepd_state_t  state_d;
  logic          tmr_load;
  logic [TW-1:0] tmr_val;
  logic          tmr_done;
  logic          launch;
  sfepd_erase_t  launch_kind;
  logic          rd_status;
  logic          rd_id;
  logic [7:0]    out_byte;
  logic [7:0]    frame_opc;
  logic [23:0]   frame_addr;
  logic          frame_8;
  logic          frame_32;

  // Pins cross into the clock domain; idle is deselected, clock low
  sfepd_sync #(
    .W (3)
  ) u_sync (
    .clock_in     (clock_in),
    .resetn_in    (resetn_in),
    .async_in     ({cs_n_in, sclk_in, si_in}),
    .reset_val_in (3'b100),
    .sync_out     (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s   = pins_s[0];

  // Edge history of the synchronised pins
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_q && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_q && !cs_n_s;
  assign cs_rise   = cs_n_s && !cs_n_d_q;

  // Input shifter, MSB first on rising edges; restarts on every select
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else if (cs_n_s) begin
      bit_cnt_q <= '0; // RULE_20
    end else if (sclk_rise) begin
      shift_q   <= {shift_q[30:0], si_s}; // RULE_20
      if (bit_cnt_q != BIT_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // Opcode latched once its eighth bit arrives
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      opc_q <= '0;
    end else if (sclk_rise && bit_cnt_q == OPC_FRAME_BITS - 6'h01) begin
      opc_q <= {shift_q[6:0], si_s}; // RULE_20
    end
  end

  // Frame view at deselect: exact length decides execution
  assign frame_8    = (bit_cnt_q == OPC_FRAME_BITS);
  assign frame_32   = (bit_cnt_q == ADDR_FRAME_BITS);
  assign frame_opc  = frame_8 ? shift_q[7:0] : shift_q[31:24];
  assign frame_addr = shift_q[23:0];

  // Block index of the address, checked against the protect bits
  function automatic logic blk_protected(input sfepd_prot_t p, input logic [23:0] a);
    logic [2:0] lvl;
    logic [6:0] blk;
    logic [6:0] span;
    logic       hit;
    lvl  = {p.protect_bit_2, p.protect_bit_1, p.protect_bit_0};
    blk  = {1'b0, a[BLK_IDX_LSB+5:BLK_IDX_LSB]};
    span = 7'h01 << (lvl - 3'h1);
    if (lvl == 3'h0) begin
      hit = 1'b0;
    end else if (lvl == 3'h7 || (p.protect_bit_4 && p.protect_bit_3)) begin
      hit = 1'b1;
    end else if (p.protect_bit_3) begin
      hit = (blk < span);
    end else begin
      hit = (blk >= NUM_BLOCKS - span);
    end
    return hit ^ p.protect_complement;
  endfunction : blk_protected

  // Chip erase needs protect bits 2..0 all clear or all set, matching complement
  function automatic logic chip_allowed(input sfepd_prot_t p);
    logic [2:0] lvl;
    lvl = {p.protect_bit_2, p.protect_bit_1, p.protect_bit_0};
    return (lvl == 3'h0 && !p.protect_complement) ||
           (lvl == 3'h7 && p.protect_complement); // RULE_10
  endfunction : chip_allowed

  // Decode at deselect; commands outside the exact frame are dropped, except the ID read release at 32 or more edges
  always_comb begin
    state_d     = state_q;
    tmr_load    = 1'b0;
    tmr_val     = '0;
    launch      = 1'b0;
    launch_kind = ER_NONE;
    unique case (state_q)
      ST_STANDBY: begin
        if (cs_rise && frame_32 && wel_q &&
            !blk_protected(prot_in, frame_addr)) begin // RULE_03 RULE_09
          if (frame_opc == OPC_HALF_BLOCK_ERASE) begin // RULE_01 RULE_04
            launch      = 1'b1;
            launch_kind = ER_HALF;
            tmr_val     = TW'(HALF_BLOCK_CYC);
          end else if (frame_opc == OPC_FULL_BLOCK_ERASE) begin // RULE_02 RULE_04
            launch      = 1'b1;
            launch_kind = ER_FULL;
            tmr_val     = TW'(FULL_BLOCK_CYC);
          end
        end else if (cs_rise && frame_8) begin
          if ((frame_opc == OPC_CHIP_ERASE_A || frame_opc == OPC_CHIP_ERASE_B) &&
              wel_q && chip_allowed(prot_in)) begin // RULE_05 RULE_03
            launch      = 1'b1;
            launch_kind = ER_CHIP;
            tmr_val     = TW'(WHOLE_CHIP_CYC);
          end else if (frame_opc == OPC_DEEP_SLEEP) begin // RULE_11
            state_d  = ST_ENTRY;
            tmr_load = 1'b1;
            tmr_val  = TW'(SLEEP_CYC);
          end
        end
        if (launch) begin
          state_d  = ST_ERASE; // RULE_06
          tmr_load = 1'b1;
        end
      end
      // Busy: deep sleep, release and ID read all have no effect
      ST_ERASE: begin
        if (tmr_done) begin
          state_d = ST_STANDBY; // RULE_07 RULE_13 RULE_19
        end
      end
      ST_ENTRY: begin
        if (tmr_done) begin
          state_d = ST_SLEEP; // RULE_11
        end
      end
      // Only the release opcode is heard in sleep
      ST_SLEEP: begin
        if (cs_rise && opc_q == OPC_WAKE_AND_ID) begin // RULE_12
          if (frame_8) begin
            state_d  = ST_WAKE; // RULE_16
            tmr_load = 1'b1;
            tmr_val  = TW'(WAKE_CYC);
          end else if (bit_cnt_q >= ADDR_FRAME_BITS) begin
            state_d  = ST_WAKE; // RULE_18
            tmr_load = 1'b1;
            tmr_val  = TW'(WAKE_ID_CYC);
          end
        end
      end
      ST_WAKE: begin
        if (tmr_done) begin
          state_d = ST_STANDBY; // RULE_16 RULE_18
        end
      end
    endcase
  end

  sfepd_timer #(
    .W (TW)
  ) u_timer (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .load_in   (tmr_load),
    .count_in  (tmr_val),
    .done_out  (tmr_done)
  );

  // Mode state; reset is the power-up standby
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_q <= ST_STANDBY; // RULE_15
    end else begin
      state_q <= state_d;
    end
  end

  // Write enable latch; dropped at launch, long before the cycle ends
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      wel_q <= WEL_RESET;
    end else if (launch) begin
      wel_q <= 1'b0; // RULE_08
    end else if (state_q == ST_STANDBY && cs_rise && frame_8) begin
      if (frame_opc == OPC_WRITE_ENABLE) begin
        wel_q <= 1'b1;
      end else if (frame_opc == OPC_WRITE_DISABLE) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Latch is visible directly, still straight from its flop
  assign write_enable_latch_out = wel_q; // RULE_08

  // Erase request to the array, held for the whole cycle
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      erase_req_out   <= '{kind: ER_NONE, addr: 24'h000000};
      erase_start_out <= 1'b0;
    end else begin
      erase_start_out <= launch; // RULE_06
      if (launch) begin
        erase_req_out <= '{kind: launch_kind, addr: frame_addr};
      end else if (state_q != ST_ERASE) begin
        erase_req_out.kind <= ER_NONE;
      end
    end
  end

  // Mode flags straight from flops
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      busy_flag_out  <= 1'b0;
      deep_sleep_out <= 1'b0;
      standby_out    <= 1'b1;
    end else begin
      busy_flag_out  <= (state_d == ST_ERASE); // RULE_07
      deep_sleep_out <= (state_d == ST_SLEEP); // RULE_11
      standby_out    <= (state_d == ST_STANDBY) && cs_n_s; // RULE_14
    end
  end

  // Readout phases: status in standby or during erase, ID only in standby or sleep
  assign rd_status = (opc_q == OPC_READ_STATUS) && (bit_cnt_q >= OPC_FRAME_BITS) &&
                     (state_q == ST_STANDBY || state_q == ST_ERASE); // RULE_07
  assign rd_id     = (opc_q == OPC_WAKE_AND_ID) && (bit_cnt_q >= ADDR_FRAME_BITS) &&
                     (state_q == ST_STANDBY || state_q == ST_SLEEP); // RULE_17 RULE_19
  assign out_byte  = rd_id ? DEVICE_ID : {6'h00, wel_q, busy_flag_out};

  // Serial out on falling edges, MSB first, byte repeats until deselect
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      so_out      <= 1'b0;
      so_oe_n_out <= 1'b1;
      out_idx_q   <= OUT_IDX_TOP;
    end else begin
      so_oe_n_out <= !(!cs_n_s && (rd_status || rd_id));
      if (cs_n_s) begin
        out_idx_q <= OUT_IDX_TOP;
      end else if (sclk_fall && (rd_status || rd_id)) begin
        so_out    <= out_byte[out_idx_q]; // RULE_17
        out_idx_q <= out_idx_q - 3'h1;
      end
    end
  end

endmodule : sfepd_top

// ==== bench/sfepd_top_sva.sv ====
// Port checker for the erase and power-down sequencer.
// Assumes one clock domain and the synchronous active-low reset.
module sfepd_top_sva
  import sfepd_pkg::*;
#(
  parameter int unsigned HALF_BLOCK_CYC = HALF_BLOCK_ERASE_TIME,
  parameter int unsigned FULL_BLOCK_CYC = FULL_BLOCK_ERASE_TIME,
  parameter int unsigned WHOLE_CHIP_CYC = WHOLE_ARRAY_ERASE_TIME
) (
  input wire logic             clock_in,
  input wire logic             resetn_in,
  input wire logic             cs_n_in,
  input wire logic             sclk_in,
  input wire logic             si_in,
  input wire sfepd_prot_t      prot_in,
  input wire logic             so_out,
  input wire logic             so_oe_n_out,
  input wire logic             busy_flag_out,
  input wire logic             write_enable_latch_out,
  input wire logic             deep_sleep_out,
  input wire logic             standby_out,
  input wire logic             erase_start_out,
  input wire sfepd_erase_req_t erase_req_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  logic [15:0] busy_cnt_q;
  logic [15:0] exp_cyc;

  // Busy length; cleared while idle so each cycle is measured alone
  always_ff @(posedge clock_in) begin
    if (!resetn_in || !busy_flag_out) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end

  // Expected length follows the held kind, so a swapped timer shows
  always_comb begin
    case (erase_req_out.kind)
      ER_HALF: exp_cyc = 16'(HALF_BLOCK_CYC);
      ER_FULL: exp_cyc = 16'(FULL_BLOCK_CYC);
      ER_CHIP: exp_cyc = 16'(WHOLE_CHIP_CYC);
      default: exp_cyc = 16'hFFFF;
    endcase
  end

  a_start_sets_busy: assert property (erase_start_out |-> busy_flag_out)
    else $error("erase launch without busy");
  a_start_single: assert property (erase_start_out |=> !erase_start_out)
    else $error("erase launch pulse too long");
  a_busy_has_cause: assert property ($rose(busy_flag_out) |-> erase_start_out)
    else $error("busy rose without a launch");
  a_busy_length: assert property ($fell(busy_flag_out) |->
    busy_cnt_q >= exp_cyc && busy_cnt_q <= exp_cyc + 16'h0003)
    else $error("erase cycle length wrong");
  a_latch_clear_end: assert property ($fell(busy_flag_out) |-> !write_enable_latch_out)
    else $error("latch still set after erase");
  a_req_held: assert property (busy_flag_out && !erase_start_out |-> $stable(erase_req_out))
    else $error("erase request moved during cycle");
  a_no_sleep_busy: assert property (busy_flag_out |-> !deep_sleep_out)
    else $error("sleep entered during erase");
  a_sleep_quiet: assert property (deep_sleep_out |-> !standby_out && !erase_start_out)
    else $error("activity while asleep");
  a_wake_holdoff: assert property ($fell(deep_sleep_out) |-> (!standby_out)[*8])
    else $error("wake delay cut short");
  a_boot_standby: assert property ($rose(resetn_in) |-> standby_out && !deep_sleep_out)
    else $error("not in standby after reset");
  a_oe_released: assert property ($rose(cs_n_in) |-> ##3 so_oe_n_out)
    else $error("serial out still driven after deselect");

  c_half: cover property (erase_start_out && erase_req_out.kind == ER_HALF);
  c_chip: cover property (erase_start_out && erase_req_out.kind == ER_CHIP);
  c_wake: cover property ($fell(deep_sleep_out));
endmodule : sfepd_top_sva

bind sfepd_top sfepd_top_sva #(.HALF_BLOCK_CYC(HALF_BLOCK_CYC),
  .FULL_BLOCK_CYC(FULL_BLOCK_CYC), .WHOLE_CHIP_CYC(WHOLE_CHIP_CYC)) u_sfepd_top_sva (
  .clock_in(clock_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
  .si_in(si_in), .prot_in(prot_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
  .busy_flag_out(busy_flag_out), .write_enable_latch_out(write_enable_latch_out),
  .deep_sleep_out(deep_sleep_out), .standby_out(standby_out),
  .erase_start_out(erase_start_out), .erase_req_out(erase_req_out)
);

// ==== bench/sfepd_host_model.sv ====
// Host side of the serial link: one mode 0 frame at a time.
// Assumes the device samples the pins with the 100 MHz clock_in.
module sfepd_host_model (
  input  wire logic clock_in,
  input  wire logic so_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      si_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Deselected with the serial clock parked low between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end

  // Half of the 80 ns serial clock period
  task automatic half;
    repeat (4) @(negedge clock_in);
  endtask : half

  // Sends n bits MSB first, then shifts in nr bits late in each high phase
  task automatic xfer(input logic [31:0] d, input int n, input int nr,
                      output logic [15:0] r);
    r = 16'h0000;
    @(negedge clock_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < n + nr; i++) begin
      si_out = (i < n) ? d[31 - i] : ~si_out;
      half();
      sclk_out = 1'b1;
      half();
      r = (i >= n) ? {r[14:0], so_in} : r;
      sclk_out = 1'b0;
    end
    half();
    cs_n_out = 1'b1;
    si_out = ~si_out; // Released line must not keep the last bit
    half();
    half();
  endtask : xfer
endmodule : sfepd_host_model

// ==== bench/sfepd_top_tb_top.sv ====
// Self-checking bench for the erase and power-down sequencer.
// Assumes the host model drives the link and the checker is bound.
module sfepd_top_tb_top
  import sfepd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clock_in = 1'b0;
  logic             resetn_in = 1'b0;
  sfepd_prot_t      prot_in = '0;
  logic             cs_n, sclk, si, so_out, so_oe_n_out, busy_flag_out;
  logic             write_enable_latch, deep_sleep_out, standby_out, erase_start_out;
  sfepd_erase_req_t erase_req_out;
  logic [15:0]      rd;
  int               err_total = 0;
  int               checks_done = 0;

  // 100 MHz system clock
  always #5 clock_in = ~clock_in;

  // Short cycle counts keep the run small
  sfepd_top #(.HALF_BLOCK_CYC(800), .FULL_BLOCK_CYC(900), .WHOLE_CHIP_CYC(1000),
    .SLEEP_CYC(20), .WAKE_CYC(40)) u_sfepd_top (
    .clock_in(clock_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .si_in(si), .prot_in(prot_in), .so_out(so_out), .so_oe_n_out(so_oe_n_out),
    .busy_flag_out(busy_flag_out), .write_enable_latch_out(write_enable_latch),
    .deep_sleep_out(deep_sleep_out), .standby_out(standby_out),
    .erase_start_out(erase_start_out), .erase_req_out(erase_req_out));
  // Undriven serial out floats to its pull-up level, so a dead enable shows
  sfepd_host_model u_sfepd_host_model (.clock_in(clock_in),
    .so_in(so_oe_n_out ? 1'b1 : so_out),
    .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input int nr);
    u_sfepd_host_model.xfer({op, a}, n, nr, rd);
  endtask : cmd

  // Bounded wait: 0 busy low, 1 asleep, 2 standby
  task automatic wait_for(input int s);
    int k;
    k = 0;
    while (k < 3000 && ((s == 0 && busy_flag_out !== 1'b0) ||
           (s == 1 && deep_sleep_out !== 1'b1) || (s == 2 && standby_out !== 1'b1))) begin
      @(negedge clock_in);
      k++;
    end
    if (k == 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_for

  // Main sequence
  initial begin
    repeat (2) @(negedge clock_in);
    resetn_in = 1'b1;
    @(negedge clock_in);
    chk({standby_out, deep_sleep_out, busy_flag_out}, 3'b100);
    cmd(OPC_HALF_BLOCK_ERASE, 24'h123456, 32, 0);
    chk({busy_flag_out, write_enable_latch}, 2'b00);
    cmd(OPC_WRITE_ENABLE, 24'h0, 8, 0);
    cmd(OPC_READ_STATUS, 24'h0, 8, 8);
    chk(rd, 16'h0002);
    cmd(OPC_FULL_BLOCK_ERASE, 24'h3F0000, 31, 0);
    chk({busy_flag_out, write_enable_latch}, 2'b01);
    cmd(OPC_HALF_BLOCK_ERASE, 24'h123456, 32, 0);
    chk({busy_flag_out, write_enable_latch}, 2'b10);
    chk({erase_req_out.kind, erase_req_out.addr[21:15]}, {ER_HALF, 7'h24});
    cmd(OPC_READ_STATUS, 24'h0, 8, 8);
    chk(rd, 16'h0001);
    cmd(OPC_DEEP_SLEEP, 24'h0, 8, 0);
    chk({deep_sleep_out, busy_flag_out}, 2'b01);
    cmd(OPC_WAKE_AND_ID, 24'h0, 32, 8);
    chk({busy_flag_out, erase_req_out.kind, rd}, {1'b1, ER_HALF, 16'h00FF});
    wait_for(0);
    cmd(OPC_READ_STATUS, 24'h0, 8, 8);
    chk({rd, deep_sleep_out}, 17'h00000);
    cmd(OPC_WRITE_ENABLE, 24'h0, 8, 0);
    cmd(OPC_FULL_BLOCK_ERASE, 24'h2A8001, 32, 0);
    chk({busy_flag_out, erase_req_out.kind, erase_req_out.addr[21:16]},
        {1'b1, ER_FULL, 6'h2A});
    wait_for(0);
    // One top block guarded; both erase sizes there must be dropped
    prot_in = sfepd_prot_t'(6'h01);
    cmd(OPC_WRITE_ENABLE, 24'h0, 8, 0);
    cmd(OPC_FULL_BLOCK_ERASE, 24'h3F8000, 32, 0);
    cmd(OPC_HALF_BLOCK_ERASE, 24'h3F0000, 32, 0);
    chk({busy_flag_out, write_enable_latch}, 2'b01);
    cmd(OPC_CHIP_ERASE_A, 24'h0, 8, 0);
    chk({busy_flag_out, write_enable_latch}, 2'b01);
    cmd(OPC_FULL_BLOCK_ERASE, 24'h000000, 32, 0);
    chk({busy_flag_out, erase_req_out.kind}, {1'b1, ER_FULL});
    wait_for(0);
    // Both chip opcodes, under the two allowed protect settings
    for (int i = 0; i < 2; i++) begin
      prot_in = sfepd_prot_t'(i ? 6'h27 : 6'h00);
      cmd(OPC_WRITE_ENABLE, 24'h0, 8, 0);
      cmd(i ? OPC_CHIP_ERASE_B : OPC_CHIP_ERASE_A, 24'h0, 16, 0);
      chk(busy_flag_out, 1'b0);
      cmd(i ? OPC_CHIP_ERASE_B : OPC_CHIP_ERASE_A, 24'h0, 8, 0);
      chk({busy_flag_out, erase_req_out.kind}, {1'b1, ER_CHIP});
      wait_for(0);
    end
    prot_in = sfepd_prot_t'(6'h00);
    cmd(OPC_DEEP_SLEEP, 24'h0, 8, 0);
    chk({deep_sleep_out, standby_out}, 2'b00);
    wait_for(1);
    cmd(OPC_WRITE_ENABLE, 24'h0, 8, 0);
    cmd(OPC_HALF_BLOCK_ERASE, 24'h0, 32, 0);
    chk({busy_flag_out, deep_sleep_out, write_enable_latch}, 3'b010);
    cmd(OPC_WAKE_AND_ID, 24'h0, 8, 0);
    chk({deep_sleep_out, standby_out}, 2'b00);
    wait_for(2);
    cmd(OPC_WAKE_AND_ID, 24'h0, 32, 16);
    chk({rd, deep_sleep_out}, {DEVICE_ID_DEFAULT, DEVICE_ID_DEFAULT, 1'b0});
    cmd(OPC_DEEP_SLEEP, 24'h0, 8, 0);
    wait_for(1);
    cmd(OPC_WAKE_AND_ID, 24'h0, 32, 16);
    chk({rd, deep_sleep_out, standby_out}, {DEVICE_ID_DEFAULT, DEVICE_ID_DEFAULT, 2'b00});
    wait_for(2);
    report_and_stop();
  end
endmodule : sfepd_top_tb_top
